// [common/cb_consts.vh]
// Purpose: shared constants of the combine buffer
// Assumes: included by bare name from src files
// Notes: memory type codes are local encodings
`ifndef CB_CONSTS_VH
`define CB_CONSTS_VH

`define CB_ADDR_W 48
`define CB_LINE_BYTES 64
`define CB_LINE_BITS 512
`define CB_OFF_W 6
`define CB_NUM_ENT 8
`define CB_WM_SMT 7
`define CB_WM_ONE 7
`define CB_TYPE_W 3

`define CB_TYPE_UC 3'h0
`define CB_TYPE_WC 3'h1
`define CB_TYPE_WT 3'h4
`define CB_TYPE_WP 3'h5
`define CB_TYPE_WB 3'h6

`define CB_SIZE_BYTE 2'h0
`define CB_SIZE_WORD 2'h1
`define CB_SIZE_DWORD 2'h2
`define CB_SIZE_QWORD 2'h3

`endif

// [src/cb_store_lane.v]
// Purpose: place one store into line byte lanes
// Assumes: store is naturally aligned inside its line
// Notes: purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "cb_consts.vh"
module cb_store_lane (
    input wire [`CB_OFF_W-1:0] offset,
    input wire [1:0] size,
    input wire [63:0] data,
    output reg [`CB_LINE_BYTES-1:0] lane_be,
    output wire [`CB_LINE_BITS-1:0] lane_data
);
    reg [`CB_LINE_BYTES-1:0] base_be;

    always @* begin
        case (size)
            `CB_SIZE_BYTE: base_be = 64'h1;
            `CB_SIZE_WORD: base_be = 64'h3;
            `CB_SIZE_DWORD: base_be = 64'hF;
            default: base_be = 64'hFF;
        endcase
        lane_be = base_be << offset;
    end

    assign lane_data = {448'h0, data} << {offset, 3'h0};
endmodule
`default_nettype wire

// [src/cb_entry.v]
// Purpose: one line-sized combining entry
// Assumes: alloc and free never hit a valid/invalid mismatch
// Notes: data bytes carry no reset
`timescale 1ns/100ps
`default_nettype none
`include "cb_consts.vh"
module cb_entry #(
    parameter TW = 42
)(
    input wire clk_sys,
    input wire rstn,
    input wire alloc,
    input wire alloc_close,
    input wire [TW-1:0] alloc_tag,
    input wire [`CB_TYPE_W-1:0] alloc_type,
    input wire alloc_thread,
    input wire merge,
    input wire close,
    input wire free,
    input wire [`CB_LINE_BYTES-1:0] lane_be,
    input wire [`CB_LINE_BITS-1:0] lane_data,
    output reg valid_reg,
    output reg open_reg,
    output reg [TW-1:0] tag_reg,
    output reg [`CB_TYPE_W-1:0] type_reg,
    output reg thread_reg,
    output reg [`CB_LINE_BYTES-1:0] mask_reg,
    output wire [`CB_LINE_BITS-1:0] data_out
);
    reg [`CB_LINE_BITS-1:0] data_reg;
    genvar k;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            valid_reg <= 1'b0;
            open_reg <= 1'b0;
            tag_reg <= {TW{1'b0}};
            type_reg <= `CB_TYPE_UC;
            thread_reg <= 1'b0;
            mask_reg <= 64'h0;
        end else if (alloc) begin
            valid_reg <= 1'b1;
            open_reg <= ~alloc_close;
            tag_reg <= alloc_tag;
            type_reg <= alloc_type;
            thread_reg <= alloc_thread;
            mask_reg <= lane_be;
        end else if (free) begin
            valid_reg <= 1'b0;
            open_reg <= 1'b0;
            mask_reg <= 64'h0;
        end else begin
            if (merge)
                mask_reg <= mask_reg | lane_be;
            if (close)
                open_reg <= 1'b0;
        end
    end

    generate
        for (k = 0; k < `CB_LINE_BYTES; k = k + 1) begin : g_byte
            always @(posedge clk_sys) begin
                if ((alloc | merge) & lane_be[k])
                    data_reg[k*8 +: 8] <= lane_data[k*8 +: 8];
            end
        end
    endgenerate

    assign data_out = data_reg;
endmodule
`default_nettype wire

// [src/cb_combine_buffer.v]
// Purpose: gather combinable stores into line entries and send closed lines out
// Assumes: one store per cycle; stores are naturally aligned in a line
// Notes: closed entries leave in age order; a closed entry waits while any older entry is still open
`timescale 1ns/100ps
`default_nettype none
`include "cb_consts.vh"
module cb_combine_buffer #(
    parameter AW = `CB_ADDR_W,
    parameter NUM_ENT = `CB_NUM_ENT,
    parameter WM_SMT = `CB_WM_SMT,
    parameter WM_ONE = `CB_WM_ONE
)(
    input wire clk_sys,
    input wire rstn,
    input wire smt_mode,
    input wire st_valid,
    input wire st_thread,
    input wire [AW-1:0] st_addr,
    input wire [1:0] st_size,
    input wire [`CB_TYPE_W-1:0] st_type,
    input wire st_stream,
    input wire [63:0] st_data,
    output reg [1:0] st_ready_reg,
    input wire ev_port_io,
    input wire ev_serialize,
    input wire ev_line_flush,
    input wire [`CB_TYPE_W-1:0] ev_flush_type,
    input wire ev_lock,
    input wire ev_uc_access,
    input wire ev_wc_read,
    input wire [AW-1:0] ev_read_addr,
    input wire ev_ad_set,
    input wire ev_barrier,
    input wire ev_irq,
    output reg wr_valid_reg,
    output reg [AW-1:0] wr_addr_reg,
    output reg [`CB_LINE_BITS-1:0] wr_data_reg,
    output reg [`CB_LINE_BYTES-1:0] wr_be_reg,
    output reg wr_full_reg,
    input wire wr_ready,
    output reg busy_reg
);
    localparam TW = AW - `CB_OFF_W;
    localparam RW = $clog2(NUM_ENT);
    localparam CW = $clog2(NUM_ENT + 1);
    localparam [CW-1:0] ONE_C = 1;
    localparam [CW-1:0] NUM_C = NUM_ENT;
    localparam [CW-1:0] WM_SMT_C = WM_SMT;
    localparam [CW-1:0] WM_ONE_C = WM_ONE;
    localparam [RW-1:0] ONE_R = 1;

    wire [NUM_ENT-1:0] e_valid;
    wire [NUM_ENT-1:0] e_open;
    wire [NUM_ENT-1:0] e_thr;
    wire [NUM_ENT*TW-1:0] e_tag;
    wire [NUM_ENT*`CB_TYPE_W-1:0] e_type;
    wire [NUM_ENT*`CB_LINE_BYTES-1:0] e_mask;
    wire [NUM_ENT*`CB_LINE_BITS-1:0] e_data;
    wire [`CB_LINE_BYTES-1:0] lane_be;
    wire [`CB_LINE_BITS-1:0] lane_data;
    wire [TW-1:0] st_tag;
    wire [TW-1:0] rd_tag;

    reg [RW-1:0] rank_reg [0:NUM_ENT-1];
    reg [CW-1:0] nvalid;
    reg [CW-1:0] tcnt0;
    reg [CW-1:0] tcnt1;
    reg [CW-1:0] nvalid_next;
    reg [CW-1:0] tcnt0_next;
    reg [CW-1:0] tcnt1_next;
    reg [CW-1:0] limit;
    reg [RW-1:0] oldest_idx;
    reg oldest_found;
    reg [RW-1:0] alloc_idx;
    reg [RW-1:0] new_rank;
    reg [NUM_ENT-1:0] hit_vec;
    reg [NUM_ENT-1:0] merge_vec;
    reg [NUM_ENT-1:0] creq;
    reg [NUM_ENT-1:0] close_vec;
    reg [NUM_ENT-1:0] alloc_vec;
    reg [NUM_ENT-1:0] free_vec;
    reg [`CB_TYPE_W-1:0] eff_type;
    reg combinable;
    reg st_acc;
    reg need_alloc;
    reg rd_hit;
    reg close_all;
    reg drain_go;
    reg oldest_thr;
    integer i;
    integer j;

    assign st_tag = st_addr[AW-1:`CB_OFF_W];
    assign rd_tag = ev_read_addr[AW-1:`CB_OFF_W];

    cb_store_lane u_lane (
        .offset(st_addr[`CB_OFF_W-1:0]),
        .size(st_size),
        .data(st_data),
        .lane_be(lane_be),
        .lane_data(lane_data)
    );

    genvar g;
    generate
        for (g = 0; g < NUM_ENT; g = g + 1) begin : g_ent
            cb_entry #(
                .TW(TW)
            ) u_entry (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .alloc(alloc_vec[g]),
                .alloc_close(~combinable),
                .alloc_tag(st_tag),
                .alloc_type(eff_type),
                .alloc_thread(st_thread),
                .merge(merge_vec[g]),
                .close(close_vec[g]),
                .free(free_vec[g]),
                .lane_be(lane_be),
                .lane_data(lane_data),
                .valid_reg(e_valid[g]),
                .open_reg(e_open[g]),
                .tag_reg(e_tag[g*TW +: TW]),
                .type_reg(e_type[g*`CB_TYPE_W +: `CB_TYPE_W]),
                .thread_reg(e_thr[g]),
                .mask_reg(e_mask[g*`CB_LINE_BYTES +: `CB_LINE_BYTES]),
                .data_out(e_data[g*`CB_LINE_BITS +: `CB_LINE_BITS])
            );
        end
    endgenerate

    always @* begin
        // Streaming stores override writeback into the combining type
        if (st_type == `CB_TYPE_WB && st_stream)
            eff_type = `CB_TYPE_WC;
        else
            eff_type = st_type;
        combinable = (eff_type == `CB_TYPE_WC);
        st_acc = st_valid & st_ready_reg[st_thread];
        nvalid = {CW{1'b0}};
        tcnt0 = {CW{1'b0}};
        tcnt1 = {CW{1'b0}};
        oldest_idx = {RW{1'b0}};
        oldest_found = 1'b0;
        alloc_idx = {RW{1'b0}};
        rd_hit = 1'b0;
        for (i = NUM_ENT - 1; i >= 0; i = i - 1) begin
            if (e_valid[i]) begin
                nvalid = nvalid + ONE_C;
                if (e_thr[i])
                    tcnt1 = tcnt1 + ONE_C;
                else
                    tcnt0 = tcnt0 + ONE_C;
                if (rank_reg[i] == {RW{1'b0}}) begin
                    oldest_idx = i[RW-1:0];
                    oldest_found = 1'b1;
                end
                if (e_tag[i*TW +: TW] == rd_tag)
                    rd_hit = 1'b1;
            end else begin
                alloc_idx = i[RW-1:0];
            end
            hit_vec[i] = e_valid[i] & e_open[i] & (e_tag[i*TW +: TW] == st_tag);
            merge_vec[i] = st_acc & hit_vec[i] & combinable
                & (e_type[i*`CB_TYPE_W +: `CB_TYPE_W] == eff_type);
        end
        oldest_thr = e_thr[oldest_idx];
        need_alloc = st_acc & ~(|merge_vec);
        close_all = ev_port_io
            | ev_serialize
            | (ev_line_flush & (ev_flush_type == `CB_TYPE_WC
                | ev_flush_type == `CB_TYPE_UC))
            | ev_lock
            | ev_uc_access | (st_acc & eff_type == `CB_TYPE_UC)
            | (ev_wc_read & rd_hit)
            | ev_ad_set
            | ev_barrier
            | ev_irq;
        for (i = 0; i < NUM_ENT; i = i + 1) begin
            creq[i] = (st_acc & hit_vec[i] & ~merge_vec[i])
                | (merge_vec[i] & (&(e_mask[i*`CB_LINE_BYTES +: `CB_LINE_BYTES] | lane_be)))
                | (st_valid & ~st_ready_reg[st_thread] & oldest_found
                    & (oldest_idx == i[RW-1:0]));
        end
        for (i = 0; i < NUM_ENT; i = i + 1) begin
            close_vec[i] = close_all;
            for (j = 0; j < NUM_ENT; j = j + 1) begin
                if (creq[j] && e_valid[j] && rank_reg[j] >= rank_reg[i])
                    close_vec[i] = 1'b1;
            end
        end
        drain_go = (~wr_valid_reg | wr_ready) & oldest_found & ~e_open[oldest_idx];
        for (i = 0; i < NUM_ENT; i = i + 1) begin
            alloc_vec[i] = need_alloc & (alloc_idx == i[RW-1:0]) & ~e_valid[i];
            free_vec[i] = drain_go & (oldest_idx == i[RW-1:0]);
        end
        new_rank = nvalid[RW-1:0] - (drain_go ? ONE_R : {RW{1'b0}});
        nvalid_next = nvalid;
        tcnt0_next = tcnt0;
        tcnt1_next = tcnt1;
        if (|alloc_vec) begin
            nvalid_next = nvalid_next + ONE_C;
            if (st_thread)
                tcnt1_next = tcnt1_next + ONE_C;
            else
                tcnt0_next = tcnt0_next + ONE_C;
        end
        if (drain_go) begin
            nvalid_next = nvalid_next - ONE_C;
            if (oldest_thr)
                tcnt1_next = tcnt1_next - ONE_C;
            else
                tcnt0_next = tcnt0_next - ONE_C;
        end
        limit = smt_mode ? WM_SMT_C : WM_ONE_C;
    end

    // Age order: rank 0 is oldest; freeing always removes rank 0
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (i = 0; i < NUM_ENT; i = i + 1)
                rank_reg[i] <= {RW{1'b0}};
        end else begin
            for (i = 0; i < NUM_ENT; i = i + 1) begin
                if (alloc_vec[i])
                    rank_reg[i] <= new_rank;
                else if (drain_go && e_valid[i] && !free_vec[i])
                    rank_reg[i] <= rank_reg[i] - ONE_R;
            end
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_ready_reg <= 2'h0;
            wr_valid_reg <= 1'b0;
            wr_addr_reg <= {AW{1'b0}};
            wr_data_reg <= {`CB_LINE_BITS{1'b0}};
            wr_be_reg <= 64'h0;
            wr_full_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            st_ready_reg[0] <= (nvalid_next < NUM_C) & (tcnt0_next < limit);
            st_ready_reg[1] <= (nvalid_next < NUM_C) & (tcnt1_next < limit) & smt_mode;
            if (drain_go) begin
                wr_valid_reg <= 1'b1;
                wr_addr_reg <= {e_tag[oldest_idx*TW +: TW], {`CB_OFF_W{1'b0}}};
                wr_data_reg <= e_data[oldest_idx*`CB_LINE_BITS +: `CB_LINE_BITS];
                wr_be_reg <= e_mask[oldest_idx*`CB_LINE_BYTES +: `CB_LINE_BYTES];
                wr_full_reg <= &e_mask[oldest_idx*`CB_LINE_BYTES +: `CB_LINE_BYTES];
            end else if (wr_ready) begin
                wr_valid_reg <= 1'b0;
            end
            busy_reg <= (nvalid_next != {CW{1'b0}}) | (drain_go | (wr_valid_reg & ~wr_ready));
        end
    end
endmodule
`default_nettype wire

// [bench/cb_combine_buffer_properties.sv]
// Purpose: port assertions of the combine buffer
// Assumes: one clock, reset active low
// Notes: bound onto every cb_combine_buffer
`timescale 1ns/100ps
`default_nettype none
`include "cb_consts.vh"
module cb_props #(
    parameter AW = 48
)(
    input wire clk_sys,
    input wire rstn,
    input wire smt_mode,
    input wire st_valid,
    input wire st_thread,
    input wire [1:0] st_ready_reg,
    input wire ev_port_io,
    input wire ev_serialize,
    input wire ev_line_flush,
    input wire [`CB_TYPE_W-1:0] ev_flush_type,
    input wire ev_lock,
    input wire ev_uc_access,
    input wire ev_ad_set,
    input wire ev_barrier,
    input wire ev_irq,
    input wire wr_valid_reg,
    input wire [AW-1:0] wr_addr_reg,
    input wire [`CB_LINE_BYTES-1:0] wr_be_reg,
    input wire wr_full_reg,
    input wire wr_ready,
    input wire busy_reg
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire close_ev = ev_port_io | ev_serialize | ev_lock | ev_uc_access | ev_ad_set | ev_irq;
    wire flush_hit = ev_line_flush && (ev_flush_type == `CB_TYPE_WC || ev_flush_type == `CB_TYPE_UC);
    // Lines held while the write port is idle
    sequence held_data;
        busy_reg && !wr_valid_reg && !$past(wr_valid_reg);
    endsequence
    hold_write_a: assert property (wr_valid_reg && !wr_ready |=> wr_valid_reg && $stable(wr_addr_reg) && $stable(wr_be_reg))
        else $error("write changed before acceptance");
    line_align_a: assert property (wr_valid_reg |-> wr_addr_reg[5:0] == 6'h00)
        else $error("write address not line aligned");
    full_flag_a: assert property (wr_valid_reg |-> wr_full_reg == (&wr_be_reg))
        else $error("full flag disagrees with byte enables");
    be_some_a: assert property (wr_valid_reg |-> (|wr_be_reg))
        else $error("write without byte enables");
    thread_cap_a: assert property (!smt_mode && !$past(smt_mode) |-> !st_ready_reg[1])
        else $error("second thread ready in single mode");
    ready_busy_a: assert property (!st_ready_reg[0] && $past(rstn) |-> busy_reg)
        else $error("store refused while empty");
    stall_drain_a: assert property (st_valid && !st_ready_reg[st_thread] && $past(rstn) |-> ##[1:300] wr_valid_reg)
        else $error("refused store did not drain oldest");
    close_event_a: assert property (close_ev ##0 held_data |-> ##[1:3] wr_valid_reg)
        else $error("event did not close combining");
    flush_type_a: assert property (flush_hit ##0 held_data |-> ##[1:3] wr_valid_reg)
        else $error("line flush did not close combining");
    barrier_drain_a: assert property ((ev_barrier || ev_irq) && !st_valid |-> ##[1:400] (!busy_reg || st_valid))
        else $error("buffer not drained after barrier");
endmodule
bind cb_combine_buffer cb_props #(.AW(AW)) u_props (
    .clk_sys, .rstn, .smt_mode, .st_valid, .st_thread, .st_ready_reg, .ev_port_io, .ev_serialize,
    .ev_line_flush, .ev_flush_type, .ev_lock, .ev_uc_access, .ev_ad_set, .ev_barrier, .ev_irq,
    .wr_valid_reg, .wr_addr_reg, .wr_be_reg, .wr_full_reg, .wr_ready, .busy_reg);
`default_nettype wire

// [bench/cb_fabric.sv]
// Purpose: fabric side of the line write port
// Assumes: slow sets wait cycles before ready
// Notes: accepted writes are logged in queues
`timescale 1ns/100ps
`default_nettype none
module cb_fabric #(
    parameter AW = 48
)(
    input wire clk_sys,
    input wire rstn,
    input wire [7:0] slow,
    input wire wr_valid_reg,
    input wire [AW-1:0] wr_addr_reg,
    input wire [511:0] wr_data_reg,
    input wire [63:0] wr_be_reg,
    input wire wr_full_reg,
    output logic wr_ready
);
    logic [7:0] cnt;
    logic [AW-1:0] a_q[$];
    logic [63:0] b_q[$];
    logic [511:0] d_q[$];
    logic f_q[$];
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_ready <= 1'b0;
            cnt <= 8'h00;
        end else if (wr_valid_reg && wr_ready) begin
            a_q.push_back(wr_addr_reg);
            b_q.push_back(wr_be_reg);
            d_q.push_back(wr_data_reg);
            f_q.push_back(wr_full_reg);
            wr_ready <= 1'b0;
            cnt <= 8'h00;
        end else if (wr_valid_reg) begin
            wr_ready <= cnt >= slow;
            cnt <= cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

// [bench/cb_combine_buffer_tb.sv]
// Purpose: self-checking bench of the combine buffer
// Assumes: fabric model takes every write
// Notes: one task per scenario
`timescale 1ns/100ps
`default_nettype none
`include "cb_consts.vh"
module cb_combine_buffer_tb;
    localparam logic [2:0] cmb = `CB_TYPE_WC;
    localparam logic [1:0] qw = `CB_SIZE_QWORD;
    logic clk_sys = 0, rstn = 0, smt_mode = 0, st_valid = 0, st_thread = 0, st_stream = 0;
    logic ev_line_flush = 0, ev_wc_read = 0;
    logic [6:0] ev = 0;
    logic [1:0] st_size = 0;
    logic [2:0] st_type = 0, ev_flush_type = 0;
    logic [7:0] slow = 0;
    logic [47:0] st_addr = 0, ev_read_addr = 0;
    logic [63:0] st_data = 0;
    wire [1:0] st_ready_reg;
    wire [47:0] wr_addr_reg;
    wire [511:0] wr_data_reg;
    wire [63:0] wr_be_reg;
    wire wr_valid_reg, wr_full_reg, wr_ready, busy_reg;
    int error_cnt = 0, n_compared = 0, b;
    cb_combine_buffer dut (.clk_sys, .rstn, .smt_mode, .st_valid, .st_thread, .st_addr, .st_size, .st_type,
        .st_stream, .st_data, .st_ready_reg, .ev_port_io(ev[0]), .ev_serialize(ev[1]), .ev_lock(ev[2]),
        .ev_uc_access(ev[3]), .ev_ad_set(ev[4]), .ev_barrier(ev[5]), .ev_irq(ev[6]), .ev_line_flush,
        .ev_flush_type, .ev_wc_read, .ev_read_addr, .wr_valid_reg, .wr_addr_reg, .wr_data_reg, .wr_be_reg,
        .wr_full_reg, .wr_ready, .busy_reg);
    cb_fabric fab (.clk_sys, .rstn, .slow, .wr_valid_reg, .wr_addr_reg, .wr_data_reg, .wr_be_reg,
        .wr_full_reg, .wr_ready);
    task chk(input logic [511:0] s, input logic [511:0] e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected at %0t: saw %0h want %0h", $time, s, e);
        end
    endtask
    task cyc(input int n);
        st_valid <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask
    task st(input logic [47:0] a, input logic [2:0] t, input logic [1:0] z, input logic [63:0] d, input logic th);
        int k;
        st_valid <= 1'b1;
        st_addr <= a;
        st_type <= t;
        st_size <= z;
        st_data <= d;
        st_thread <= th;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (st_ready_reg[th] !== 1'b1 && k < 80);
        chk(st_ready_reg[th], 1'b1);
    endtask
    task pulse(input int k);
        ev[k] <= 1'b1;
        cyc(1);
        ev <= 7'h00;
    endtask
    task wr_wait(input int n);
        int k;
        k = 0;
        while (fab.a_q.size() < n && k < 300) begin
            @(posedge clk_sys);
            k++;
        end
        chk(fab.a_q.size(), n);
    endtask
    task expw(input int i, input logic [47:0] a, input logic [63:0] e, input logic f);
        chk(fab.a_q[i], a);
        chk(fab.b_q[i], e);
        chk(fab.f_q[i], f);
    endtask
    task t_full;
        logic [511:0] e;
        b = fab.a_q.size();
        for (int i = 7; i >= 0; i--) begin
            e[64*i +: 64] = 64'h0101010101010101 * (i + 1);
            st(48'h1000 + 8 * i, cmb, qw, e[64*i +: 64], 1'b0);
        end
        cyc(2);
        wr_wait(b + 1);
        chk(fab.d_q[b], e);
        expw(b, 48'h1000, '1, 1'b1);
        $display("full line test done");
    endtask
    task t_part;
        b = fab.a_q.size();
        st(48'h2003, cmb, `CB_SIZE_BYTE, 64'h5A, 1'b0);
        st(48'h2010, cmb, `CB_SIZE_WORD, 64'hBEEF, 1'b0);
        st(48'h2024, cmb, `CB_SIZE_DWORD, 64'h12345678, 1'b0);
        cyc(20);
        chk(fab.a_q.size(), b);
        pulse(5);
        wr_wait(b + 1);
        expw(b, 48'h2000, 64'h000000F000030008, 1'b0);
        chk(fab.d_q[b][128 +: 16], 16'hBEEF);
        cyc(3);
        chk(busy_reg, 1'b0);
        $display("partial line test done");
    endtask
    task t_types;
        logic [2:0] ty [4];
        ty = '{`CB_TYPE_UC, `CB_TYPE_WT, `CB_TYPE_WP, `CB_TYPE_WB};
        for (int i = 0; i < 4; i++) begin
            b = fab.a_q.size();
            st(48'h3000, ty[i], qw, 64'h1, 1'b0);
            st(48'h3008, ty[i], qw, 64'h2, 1'b0);
            cyc(2);
            pulse(5);
            wr_wait(b + 2);
            expw(b + 1, 48'h3000, 64'hFF00, 1'b0);
        end
        b = fab.a_q.size();
        st_stream <= 1'b1;
        st(48'h3000, `CB_TYPE_WB, qw, 64'h1, 1'b0);
        st(48'h3008, `CB_TYPE_WB, qw, 64'h2, 1'b0);
        st_stream <= 1'b0;
        cyc(2);
        pulse(5);
        wr_wait(b + 1);
        expw(b, 48'h3000, 64'hFFFF, 1'b0);
        b = fab.a_q.size();
        st(48'h4000, cmb, qw, 64'h1, 1'b0);
        st(48'h4008, `CB_TYPE_WT, qw, 64'h2, 1'b0);
        cyc(2);
        wr_wait(b + 2);
        expw(b, 48'h4000, 64'hFF, 1'b0);
        $display("memory type test done");
    endtask
    task t_events;
        for (int k = 0; k < 7; k++) begin
            b = fab.a_q.size();
            st(48'h5000, cmb, qw, k, 1'b0);
            cyc(4);
            chk(fab.a_q.size(), b);
            pulse(k);
            wr_wait(b + 1);
        end
        for (int t = 0; t < 8; t++) begin
            b = fab.a_q.size();
            st(48'h5040, cmb, qw, t, 1'b0);
            cyc(2);
            ev_flush_type <= t[2:0];
            ev_line_flush <= 1'b1;
            cyc(1);
            ev_line_flush <= 1'b0;
            cyc(6);
            chk(fab.a_q.size(), b + ((t == 0 || t == 1) ? 1 : 0));
            pulse(5);
            wr_wait(b + 1);
        end
        for (int m = 0; m < 2; m++) begin
            b = fab.a_q.size();
            st(48'h5080, cmb, qw, m, 1'b0);
            cyc(2);
            ev_read_addr <= m ? 48'h5088 : 48'h50C0;
            ev_wc_read <= 1'b1;
            cyc(1);
            ev_wc_read <= 1'b0;
            cyc(6);
            chk(fab.a_q.size(), b + m);
            pulse(5);
            wr_wait(b + 1);
        end
        $display("close event test done");
    endtask
    task t_smt;
        b = fab.a_q.size();
        rstn <= 1'b0;
        smt_mode <= 1'b1;
        slow <= 8'h03;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        for (int i = 0; i < 7; i++) st(48'h8000 + 64 * i, cmb, 2'h0, i, 1'b0);
        cyc(2);
        chk(st_ready_reg, 2'b10);
        st(48'h81C0, cmb, 2'h0, 64'h7, 1'b1);
        cyc(2);
        chk(st_ready_reg, 2'b00);
        chk(fab.a_q.size(), b);
        st(48'h8200, cmb, 2'h0, 64'h8, 1'b0);
        cyc(1);
        wr_wait(b + 1);
        chk(fab.a_q[b], 48'h8000);
        pulse(5);
        wr_wait(b + 9);
        for (int i = 0; i < 9; i++) chk(fab.a_q[b + i], 48'h8000 + 64 * i);
        $display("thread stall test done");
    endtask
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // Whole run needs a few hundred cycles
    initial begin
        #200000;
        error_cnt++;
        end_of_test;
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_full;
        t_part;
        t_types;
        t_events;
        t_smt;
        end_of_test;
    end
endmodule
`default_nettype wire
